// File: isfd_pkg.sv
package isfd_pkg;

	// Serial framing
	localparam int          SEG_BITS      = 16;
	localparam logic [4:0]  SEG_LEN       = 5'h10;
	localparam logic [4:0]  RECOVER_EDGES = 5'h11;
	localparam logic [7:0]  MAX_READS     = 8'h0C;

	// Command word layout: write flag, byte address, write data
	localparam int          CMD_WR_BIT    = 15;
	localparam int          CMD_ADDR_HI   = 14;
	localparam int          CMD_ADDR_LO   = 8;
	localparam logic [6:0]  BURST_ADDR    = 7'h34;
	localparam logic [2:0]  BURST_WORDS   = 3'h6;

	// Word indices of the register map (byte address = 2 * index)
	localparam logic [3:0]  IDX_DIAG      = 4'h0;
	localparam logic [3:0]  IDX_DEC       = 4'hD;
	localparam logic [3:0]  IDX_FILT      = 4'hE;
	localparam logic [3:0]  IDX_PROD      = 4'hF;
	localparam logic [6:0]  ADDR_DEC_LO   = 7'h1A;
	localparam logic [6:0]  ADDR_DEC_HI   = 7'h1B;
	localparam logic [6:0]  ADDR_FILT     = 7'h1C;
	localparam logic [6:0]  ADDR_DIAG     = 7'h00;

	// Diagnostic flag positions
	localparam int          DIAG_DP_OVR   = 0;
	localparam int          DIAG_PORT_OVR = 1;
	localparam int          DIAG_LOCKED   = 2;

	// Filter settings and datapath widths
	localparam int          DEC_W         = 11;
	localparam int          FILT_W        = 3;
	localparam int          ACC_W         = 48;
	localparam int          GYRO_W        = 16;
	localparam int          ACCL_W        = 20;
	localparam logic [10:0] DEC_RESET     = 11'h000;
	localparam logic [2:0]  FILT_RESET    = 3'h0;

	// Port health
	typedef enum logic [2:0] {
		ISFD_OK   = 3'b001,
		ISFD_OVR  = 3'b010,
		ISFD_LOCK = 3'b100
	} isfd_state_t;

endpackage

// File: isfd_link.sv
`timescale 1ns/1ns
module isfd_link (
	input  wire logic        sclk,
	input  wire logic        rst_b,
	input  wire logic        cs_b,
	input  wire logic        din,
	input  wire logic        port_fault,
	input  wire logic [15:0] snap [16],
	output logic             dout,
	output logic             dout_oe,
	output logic [4:0]       total_count,
	output logic [3:0]       mod_count,
	output logic             frame_tgl,
	output logic             seg_tgl,
	output logic             wr_tgl,
	output logic [15:0]      wr_word
);
	logic        first;
	logic [14:0] rx;
	logic [15:0] answer;
	logic [15:0] tx;
	logic [1:0]  fault_sync;
	logic        burst_on;
	logic [2:0]  burst_k;

	wire  [3:0]  next_mod   = first ? 4'h1 : 4'(mod_count + 4'h1);
	wire  [4:0]  next_total = first ? 5'h01 :
	                          (&total_count) ? total_count : 5'(total_count + 5'h01);
	wire         seg_end    = (next_mod == 4'h0);
	wire  [15:0] next_rx    = {rx, din};
	wire  [6:0]  cmd_addr   = next_rx[isfd_pkg::CMD_ADDR_HI:isfd_pkg::CMD_ADDR_LO];
	wire  [3:0]  cmd_idx    = cmd_addr[4:1];
	wire         mapped     = (cmd_addr[6:5] == 2'h0);
	wire         is_write   = next_rx[isfd_pkg::CMD_WR_BIT];
	wire         blocked    = fault_sync[1];
	wire  [3:0]  burst_idx  = {burst_k, 1'b0};

	// Marks the first rising edge of a frame; chip select high presets it
	always_ff @(posedge sclk or posedge cs_b) begin
		if (cs_b)
			first <= 1'b1;
		else
			first <= 1'b0;
	end

	// Fault level from the system clock side
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b)
			fault_sync <= 2'h0;
		else
			fault_sync <= {fault_sync[0], port_fault};
	end

	// Edge counting and receive shifting
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			mod_count   <= 4'h0;
			total_count <= 5'h00;
			rx          <= 15'h0000;
			frame_tgl   <= 1'b0;
		end else begin
			mod_count   <= next_mod;
			total_count <= next_total;
			rx          <= next_rx[14:0];
			if (first)
				frame_tgl <= ~frame_tgl;
		end
	end

	// Segment decode: writes, read answers and burst sequencing
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			answer   <= 16'h0000;
			seg_tgl  <= 1'b0;
			wr_tgl   <= 1'b0;
			wr_word  <= 16'h0000;
			burst_on <= 1'b0;
			burst_k  <= 3'h0;
		end else if (first) begin
			burst_on <= 1'b0;
		end else if (seg_end) begin
			seg_tgl <= ~seg_tgl;
			if (blocked) begin
				answer   <= 16'h0000;
				burst_on <= 1'b0;
			end else if (burst_on) begin
				answer   <= snap[burst_idx];
				burst_k  <= 3'(burst_k + 3'h1);
				burst_on <= (burst_k != isfd_pkg::BURST_WORDS);
			end else if (is_write) begin
				wr_word <= next_rx;
				wr_tgl  <= ~wr_tgl;
				answer  <= 16'h0000;
			end else if (cmd_addr == isfd_pkg::BURST_ADDR) begin
				answer   <= snap[isfd_pkg::IDX_DIAG];
				burst_on <= 1'b1;
				burst_k  <= 3'h1;
			end else begin
				answer <= mapped ? snap[cmd_idx] : 16'h0000;
			end
		end
	end

	// Output shifter moves on falling edges, loads at each segment start;
	// a blocked port empties it between loads, but up to two bits of the answer loaded at frame start still leave
	always_ff @(negedge sclk or negedge rst_b) begin
		if (!rst_b)
			tx <= 16'h0000;
		else if (first || mod_count == 4'h0)
			tx <= answer;
		else if (blocked)
			tx <= 16'h0000;
		else
			tx <= {tx[14:0], 1'b0};
	end

	assign dout    = tx[15];
	assign dout_oe = ~cs_b;

endmodule

// File: isfd_top.sv
`timescale 1ns/1ns
module isfd_top #(
	parameter logic [15:0] PRODUCT_CODE = 16'h5A5A  // Arbitrary identity value
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              sclk,
	input  wire logic              cs_b,
	input  wire logic              din,
	output logic                   dout,
	output logic                   dout_oe,
	input  wire logic              sensor_strobe,
	input  wire logic [15:0]       gyro_x_raw,
	input  wire logic [15:0]       gyro_y_raw,
	input  wire logic [15:0]       gyro_z_raw,
	input  wire logic [19:0]       accel_x_raw,
	input  wire logic [19:0]       accel_y_raw,
	input  wire logic [19:0]       accel_z_raw,
	output logic                   sample_ready_output,
	output logic                   port_overrun,
	output logic                   port_locked
);
	localparam int AW = isfd_pkg::ACC_W;

	isfd_pkg::isfd_state_t state;
	isfd_pkg::isfd_state_t next_state;

	logic [isfd_pkg::DEC_W-1:0]  decimation_setting;
	logic [isfd_pkg::FILT_W-1:0] averaging_filter_setting;
	logic [15:0] snap [16];
	logic [15:0] live [16];
	logic signed [AW-1:0] raw_ext [6];
	logic [4:0]  total_count;
	logic [3:0]  mod_count;
	logic        frame_tgl;
	logic        seg_tgl;
	logic        wr_tgl;
	logic [15:0] wr_word;
	logic [1:0]  cs_sync;
	logic        cs_prev;
	logic [1:0]  fr_sync;
	logic        fr_seen;
	logic [2:0]  wr_sync;
	logic [2:0]  seg_sync;
	logic [7:0]  cnt_a;
	logic [7:0]  cnt_b;
	logic [10:0] cnt_d;
	logic        va;
	logic        vb;
	logic        dp_overrun;
	logic [7:0]  read_count;

	// Serial port engine on the link clock
	isfd_link u_link (
		.sclk        (sclk),
		.rst_b       (rst_b),
		.cs_b        (cs_b),
		.din         (din),
		.port_fault  (state != isfd_pkg::ISFD_OK),
		.snap        (snap),
		.dout        (dout),
		.dout_oe     (dout_oe),
		.total_count (total_count),
		.mod_count   (mod_count),
		.frame_tgl   (frame_tgl),
		.seg_tgl     (seg_tgl),
		.wr_tgl      (wr_tgl),
		.wr_word     (wr_word)
	);

	// Frame end and event decode; counts are still once chip select is high
	wire frame_end = cs_sync[1] & ~cs_prev;
	wire new_frame = frame_end & (fr_sync[1] != fr_seen);
	wire underrun  = (total_count < isfd_pkg::SEG_LEN) & (mod_count != 4'h0);
	wire misframed = (mod_count != 4'h0);
	wire recovery  = (total_count == isfd_pkg::RECOVER_EDGES);
	wire wr_evt    = wr_sync[2] ^ wr_sync[1];
	wire seg_evt   = seg_sync[2] ^ seg_sync[1];
	wire [6:0] wr_addr = wr_word[isfd_pkg::CMD_ADDR_HI:isfd_pkg::CMD_ADDR_LO];
	wire wr_ok     = wr_evt & (state == isfd_pkg::ISFD_OK);

	// Crossings from the link clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cs_sync  <= 2'h3;
			cs_prev  <= 1'b1;
			fr_sync  <= 2'h0;
			fr_seen  <= 1'b0;
			wr_sync  <= 3'h0;
			seg_sync <= 3'h0;
		end else begin
			cs_sync  <= {cs_sync[0], cs_b};
			cs_prev  <= cs_sync[1];
			fr_sync  <= {fr_sync[0], frame_tgl};
			wr_sync  <= {wr_sync[1:0], wr_tgl};
			seg_sync <= {seg_sync[1:0], seg_tgl};
			if (frame_end)
				fr_seen <= fr_sync[1];
		end
	end

	// Port health machine
	always_comb begin
		next_state = state;
		unique case (state)
			isfd_pkg::ISFD_OK: begin
				if (new_frame && underrun)
					next_state = isfd_pkg::ISFD_LOCK;
				else if (new_frame && misframed)
					next_state = isfd_pkg::ISFD_OVR;
			end
			isfd_pkg::ISFD_OVR: begin
				if (new_frame && underrun && !recovery)
					next_state = isfd_pkg::ISFD_LOCK;
				else if (new_frame && misframed && recovery)
					next_state = isfd_pkg::ISFD_OK;
			end
			isfd_pkg::ISFD_LOCK:
				next_state = isfd_pkg::ISFD_LOCK;
			default:
				next_state = isfd_pkg::ISFD_LOCK;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			state <= isfd_pkg::ISFD_OK;
		else
			state <= next_state;
	end

	assign port_overrun = (state == isfd_pkg::ISFD_OVR);
	assign port_locked  = (state == isfd_pkg::ISFD_LOCK);

	// Filter settings written over the serial port
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			decimation_setting       <= isfd_pkg::DEC_RESET;
			averaging_filter_setting <= isfd_pkg::FILT_RESET;
		end else if (wr_ok) begin
			if (wr_addr == isfd_pkg::ADDR_DEC_LO)
				decimation_setting[7:0] <= wr_word[7:0];
			if (wr_addr == isfd_pkg::ADDR_DEC_HI)
				decimation_setting[10:8] <= wr_word[2:0];
			if (wr_addr == isfd_pkg::ADDR_FILT)
				averaging_filter_setting <= wr_word[2:0];
		end
	end

	// Segments since last ready pulse; the set wins over a clearing write
	wire dp_set = seg_evt & (read_count >= isfd_pkg::MAX_READS);
	wire dp_clr = wr_ok & (wr_addr == isfd_pkg::ADDR_DIAG);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			read_count <= 8'h00;
			dp_overrun <= 1'b0;
		end else begin
			if (sample_ready_output)
				read_count <= 8'h00;
			else if (seg_evt && read_count != 8'hFF)
				read_count <= 8'(read_count + 8'h01);
			if (dp_set)
				dp_overrun <= 1'b1;
			else if (dp_clr)
				dp_overrun <= 1'b0;
		end
	end

	// Stage timing shared by all axes
	wire [7:0] f_len  = 8'(9'h001 << averaging_filter_setting);
	wire done_a = sensor_strobe & (cnt_a >= 8'(f_len - 8'h01));
	wire done_b = va & (cnt_b >= 8'(f_len - 8'h01));
	wire done_d = vb & (cnt_d >= decimation_setting);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_a <= 8'h00;
			cnt_b <= 8'h00;
			cnt_d <= 11'h000;
			va    <= 1'b0;
			vb    <= 1'b0;
			sample_ready_output <= 1'b0;
		end else begin
			cnt_a <= done_a ? 8'h00 : (sensor_strobe ? 8'(cnt_a + 8'h01) : cnt_a);
			cnt_b <= done_b ? 8'h00 : (va ? 8'(cnt_b + 8'h01) : cnt_b);
			cnt_d <= done_d ? 11'h000 : (vb ? 11'(cnt_d + 11'h001) : cnt_d);
			va    <= done_a;
			vb    <= done_b;
			sample_ready_output <= done_d;
		end
	end

	// Bit growth: ceil(log2(decimation + 1)) plus the setting for each averaging stage
	function automatic logic [5:0] isfd_grow(input logic [10:0] dec, input logic [2:0] flt);
		logic [11:0] n;
		logic [5:0]  b;
		n = 12'(dec) + 12'h001;
		b = 6'h00;
		for (int k = 0; k < 12; k++) begin
			if ((12'h001 << k) < n)
				b = 6'(k + 1);
		end
		return 6'(b + {2'h0, flt, 1'b0});
	endfunction

	wire [5:0] grow = isfd_grow(decimation_setting, averaging_filter_setting);

	assign raw_ext[0] = AW'($signed(gyro_x_raw));
	assign raw_ext[1] = AW'($signed(gyro_y_raw));
	assign raw_ext[2] = AW'($signed(gyro_z_raw));
	assign raw_ext[3] = AW'($signed(accel_x_raw));
	assign raw_ext[4] = AW'($signed(accel_y_raw));
	assign raw_ext[5] = AW'($signed(accel_z_raw));

	// Per-axis accumulators and left-justified output words
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_axis
			localparam logic [5:0] BASE = (i < 3) ? 6'(isfd_pkg::GYRO_W) : 6'(isfd_pkg::ACCL_W);
			logic signed [AW-1:0] acc_a;
			logic signed [AW-1:0] sum_a;
			logic signed [AW-1:0] acc_b;
			logic signed [AW-1:0] sum_b;
			logic signed [AW-1:0] acc_d;
			logic signed [AW-1:0] res;
			wire [5:0]    shamt = 6'(6'(AW) - 6'(BASE + grow));
			wire [AW-1:0] just  = res << shamt;

			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					acc_a <= '0;
					sum_a <= '0;
					acc_b <= '0;
					sum_b <= '0;
					acc_d <= '0;
					res   <= '0;
				end else begin
					if (sensor_strobe)
						acc_a <= done_a ? '0 : AW'(acc_a + raw_ext[i]);
					if (done_a)
						sum_a <= AW'(acc_a + raw_ext[i]);
					if (va)
						acc_b <= done_b ? '0 : AW'(acc_b + sum_a);
					if (done_b)
						sum_b <= AW'(acc_b + sum_a);
					if (vb)
						acc_d <= done_d ? '0 : AW'(acc_d + sum_b);
					if (done_d)
						res <= AW'(acc_d + sum_b);
				end
			end

			assign live[2*i+1] = just[AW-17:AW-32];   // Lower word
			assign live[2*i+2] = just[AW-1:AW-16];    // Upper word
		end
	endgenerate

	assign live[isfd_pkg::IDX_DIAG] = {13'h0000, port_locked, port_overrun, dp_overrun};
	assign live[isfd_pkg::IDX_DEC]  = {5'h00, decimation_setting};
	assign live[isfd_pkg::IDX_FILT] = {13'h0000, averaging_filter_setting};
	assign live[isfd_pkg::IDX_PROD] = PRODUCT_CODE;

	// Register image seen by the link, frozen while a frame is open
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < 16; k++)
				snap[k] <= 16'h0000;
		end else if (cs_sync[1]) begin
			for (int k = 0; k < 16; k++)
				snap[k] <= live[k];
		end
	end

endmodule

// File: isfd_top_sva.sv
`timescale 1ns/1ns
module isfd_top_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic sensor_strobe,
	input wire logic sample_ready_output,
	input wire logic port_overrun,
	input wire logic port_locked
);
	logic [1:0] n_edge;

	// Rising link edges in the frame, saturating at 3
	always_ff @(posedge sclk or posedge cs_b) begin
		if (cs_b) begin
			n_edge <= 2'h0;
		end else if (n_edge != 2'h3) begin
			n_edge <= n_edge + 2'h1;
		end
	end

	// System clock domain
	chk_oe_tracks_cs: assert property (@(posedge clk) disable iff (!rst_b)
		dout_oe == !cs_b) else $error("dout_oe differs from chip select");
	chk_ready_one_clk: assert property (@(posedge clk) disable iff (!rst_b)
		sample_ready_output |=> !sample_ready_output) else $error("ready pulse too long");
	chk_ready_from_strobe: assert property (@(posedge clk) disable iff (!rst_b)
		sample_ready_output |-> $past(sensor_strobe, 3))
		else $error("ready without a strobe");
	chk_lock_sticky: assert property (@(posedge clk) disable iff (!rst_b)
		port_locked |=> port_locked) else $error("lock released without reset");
	chk_fault_exclusive: assert property (@(posedge clk) disable iff (!rst_b)
		!(port_locked && port_overrun)) else $error("locked and overrun together");
	chk_fault_after_frame: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(port_overrun) || $rose(port_locked) |-> cs_b) else $error("fault inside frame");
	chk_recover_after_frame: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(port_overrun) |-> cs_b && $past(cs_b)) else $error("recovery inside frame");
	// Link clock domain: a faulted port answers zero from the fourth rising edge of a frame
	chk_refused_zero: assert property (@(posedge sclk) disable iff (!rst_b)
		(port_locked || port_overrun) && !cs_b && n_edge == 2'h3 |-> !dout)
		else $error("faulted port drives data");

	cover property (@(posedge clk) $rose(port_overrun));
	cover property (@(posedge clk) $rose(port_locked));
	cover property (@(posedge clk) sample_ready_output);
endmodule

bind isfd_top isfd_top_sva i_chk (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b),
	.dout(dout), .dout_oe(dout_oe), .sensor_strobe(sensor_strobe),
	.sample_ready_output(sample_ready_output), .port_overrun(port_overrun),
	.port_locked(port_locked));

// File: isfd_host_model.sv
`timescale 1ns/1ns
module isfd_host_model (
	output logic      sclk,
	output logic      cs_b,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b1;
		cs_b = 1'b1;
		din = 1'b0;
	end

	// One frame, mode 3, MSB first from tx[127]; odd lead-in keeps phase off clk
	task automatic xfer(input int edges, input logic [127:0] tx, output logic [127:0] rx);
		rx = '0;
		cs_b = 1'b0;
		#35;
		for (int i = 0; i < edges; i++) begin
			sclk = 1'b0;
			din = tx[127-i];
			#24;
			sclk = 1'b1;
			rx[127-i] = dout;
			#24;
		end
		cs_b = 1'b1;
		din = ~din; // Released line shows no stale value
		#101;
	endtask

	// 17-edge frame then a read-only check, at most 15 tries
	task automatic recover(input logic [15:0] code, output int tries);
		logic [127:0] rx;
		tries = 0;
		do begin
			xfer(17, '0, rx);
			xfer(32, {16'h1E00, 112'h0}, rx);
			tries++;
		end while (rx[111:96] !== code && tries < 15);
	endtask
endmodule

// File: isfd_top_test.sv
`timescale 1ns/1ns
module isfd_top_test;
	localparam logic [15:0] PCODE = 16'hC3A5; // Arbitrary identity value
	logic         clk = 1'b0;
	logic         rst_b = 1'b0;
	logic         sensor_strobe = 1'b0;
	logic [15:0]  gx = 16'h1234;
	logic [19:0]  ax = 20'h2468A;
	logic [15:0]  gyro_x_raw, gyro_y_raw, gyro_z_raw;
	logic [19:0]  accel_x_raw, accel_y_raw, accel_z_raw;
	wire          sclk, cs_b, din, dout, ready, ovr, lock;
	logic [127:0] rx;
	int           n_errors = 0;
	int           checked = 0;
	int           n_ready = 0;

	always #4 clk = ~clk;
	always @(negedge clk) if (ready === 1'b1) n_ready++;

	isfd_top #(.PRODUCT_CODE(PCODE)) i_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk),
		.cs_b(cs_b), .din(din), .dout(dout), .dout_oe(), .sensor_strobe(sensor_strobe),
		.gyro_x_raw(gyro_x_raw), .gyro_y_raw(gyro_y_raw), .gyro_z_raw(gyro_z_raw),
		.accel_x_raw(accel_x_raw), .accel_y_raw(accel_y_raw), .accel_z_raw(accel_z_raw),
		.sample_ready_output(ready), .port_overrun(ovr), .port_locked(lock));
	isfd_host_model i_host (.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout));

	task automatic give_verdict;
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask

	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		i_host.xfer(32, {1'b0, a, 8'h00, 112'h0}, rx);
		d = rx[111:96];
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		i_host.xfer(16, {1'b1, a, d, 112'h0}, rx);
	endtask

	// Strobes four clocks apart; x axes alternate base and base plus one
	task automatic feed(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			gyro_x_raw = gx + 16'(i & 1);
			accel_x_raw = ax + 20'(i & 1);
			sensor_strobe = 1'b1;
			@(negedge clk);
			sensor_strobe = 1'b0;
			repeat (2) @(negedge clk);
		end
		#100;
	endtask

	task automatic t_default;
		logic [15:0] d;
		int          r0;
		r0 = n_ready;
		feed(1);
		cmp("ready count", 16'h0001, 16'(n_ready - r0));
		i_host.xfer(80, {16'h0400, 16'h0200, 16'h1000, 16'h0E00, 64'h0}, rx);
		cmp("gyro upper", gx, rx[111:96]);
		cmp("gyro lower", 16'h0000, rx[95:80]);
		cmp("accel upper", ax[19:4], rx[79:64]);
		cmp("accel lower", {ax[3:0], 12'h000}, rx[63:48]);
		rd(7'h1E, d);
		cmp("product code", PCODE, d);
	endtask

	task automatic t_burst;
		logic [15:0] d;
		feed(1);
		i_host.xfer(128, {16'h3400, 112'h0}, rx);
		cmp("burst diag", 16'h0000, rx[111:96]);
		cmp("burst gx", gx, rx[95:80]);
		cmp("burst gy", gyro_y_raw, rx[79:64]);
		cmp("burst gz", gyro_z_raw, rx[63:48]);
		cmp("burst ax", ax[19:4], rx[47:32]);
		cmp("burst ay", accel_y_raw[19:4], rx[31:16]);
		cmp("burst az", accel_z_raw[19:4], rx[15:0]);
		repeat (4) rd(7'h00, d);
		cmp("diag overrun", 16'h0001, d);
		feed(1);
		wr(7'h00, 8'h00);
		rd(7'h00, d);
		cmp("diag cleared", 16'h0000, d);
	endtask

	// Settings pairs: decimation 1, filter 1, then both at 7 and 2
	task automatic t_widen;
		logic [7:0] dec [3] = '{8'h01, 8'h00, 8'h07};
		logic [7:0] flt [3] = '{8'h00, 8'h01, 8'h02};
		logic [15:0] d;
		for (int k = 0; k < 3; k++) begin
			wr(7'h1A, dec[k]);
			wr(7'h1C, flt[k]);
			feed(3 * ((dec[k] + 1) << (2 * flt[k])));
			i_host.xfer(80, {16'h0400, 16'h0200, 16'h1A00, 16'h1C00, 64'h0}, rx);
			cmp("wide upper", gx, rx[111:96]);
			cmp("wide lower", 16'h8000, rx[95:80]);
			cmp("dec setting", {8'h00, dec[k]}, rx[79:64]);
			cmp("filt setting", {8'h00, flt[k]}, rx[63:48]);
		end
		wr(7'h1A, 8'h00);
		wr(7'h1C, 8'h00);
		wr(7'h1B, 8'h05);
		rd(7'h1A, d);
		cmp("dec high bits", 16'h0500, d);
		wr(7'h1B, 8'h00);
		rd(7'h22, d);
		cmp("unmapped read", 16'h0000, d);
	endtask

	task automatic t_overrun;
		logic [15:0] d;
		int          tries;
		i_host.xfer(20, '0, rx);
		cmp("overrun flag", 16'h0001, {15'h0, ovr});
		rd(7'h1E, d);
		cmp("refused read", 16'h0000, d);
		wr(7'h1C, 8'h03);
		i_host.recover(PCODE, tries);
		cmp("recover tries", 16'h0001, 16'(tries));
		cmp("overrun clear", 16'h0000, {15'h0, ovr});
		rd(7'h1C, d);
		cmp("ignored write", 16'h0000, d);
	endtask

	task automatic t_underrun;
		logic [15:0] d;
		int          tries;
		i_host.xfer(8, '0, rx);
		cmp("lock flag", 16'h0001, {15'h0, lock});
		i_host.recover(PCODE, tries);
		cmp("lock tries", 16'h000F, 16'(tries));
		cmp("still locked", 16'h0001, {15'h0, lock});
		@(negedge clk);
		rst_b = 1'b0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		cmp("lock after reset", 16'h0000, {15'h0, lock});
		rd(7'h1E, d);
		cmp("code after reset", PCODE, d);
	endtask

	initial begin
		gyro_x_raw = gx;
		gyro_y_raw = 16'h0F0F;
		gyro_z_raw = 16'h7001;
		accel_x_raw = ax;
		accel_y_raw = 20'h13579;
		accel_z_raw = 20'h7ACE1;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		t_default;
		t_burst;
		t_widen;
		t_overrun;
		t_underrun;
		give_verdict;
	end

	// Watchdog, several times the expected run length
	initial begin
		#400000;
		n_errors++;
		give_verdict;
	end
endmodule
